//--- gtmc_defines.svh
/*
  Constants of the gas transmitter mode controller: timing, loop currents
  and display sequence length.
  Assumes a 125 MHz system clock; loop currents are coded in microamps.
*/
`ifndef GTMC_DEFINES_SVH
`define GTMC_DEFINES_SVH
`define GTMC_CLK_NS 8
`define GTMC_TICK_NS 1000000
`define GTMC_STEP_MS 1000
`define GTMC_BLINK_MS 500
`define GTMC_STARTUP_MS 300000
`define GTMC_FULLHOLD_MS 120000
`define GTMC_PARTHOLD_MS 480000
`define GTMC_TESTWIN_MS 600000
`define GTMC_LOCK_UA 16'h0fa0
`define GTMC_O2_LOCK_UA 16'h43f8
`define GTMC_MID_UA 16'h2ee0
`define GTMC_FULL_UA 16'h4e20
`define GTMC_TROUBLE_UA 16'h0e10
`define GTMC_ITEM_LAST 4'hb
`define GTMC_PASS_DIV 16'h000a
`endif

//--- gtmc_pkg.sv
/*
  Types of the gas transmitter mode controller.
  Assumes gtmc_defines.svh for all numeric constants.
*/
package gtmc_pkg;
  typedef enum logic [12:0] {
    ST_POWERUP = 13'h0001, ST_DELAY = 13'h0002, ST_NORMAL = 13'h0004,
    ST_MENU_REVIEW_MENU = 13'h0008, ST_MENU_TEST = 13'h0010, ST_MENU_CAL = 13'h0020,
    ST_REVIEW_MENU_SHOW = 13'h0040, ST_PROBE = 13'h0080, ST_SIM_PROMPT = 13'h0100,
    ST_SIM = 13'h0200, ST_SELFTEST = 13'h0400, ST_CAL_ZERO = 13'h0800,
    ST_CAL_SPAN = 13'h1000
  } gtmc_state_t;
  typedef enum logic [2:0] {
    HOLD_NONE = 3'h1, HOLD_FULL = 3'h2, HOLD_PART = 3'h4
  } gtmc_hold_t;
  typedef enum logic [4:0] {
    SCR_CONC = 5'h00, SCR_LOAD = 5'h01, SCR_FIRMWARE = 5'h02, SCR_MODREV = 5'h03,
    SCR_GAS_CODE = 5'h04, SCR_RANGE = 5'h05, SCR_UNDERRANGE = 5'h06, SCR_GENERATOR = 5'h07,
    SCR_SELFTEST_EN = 5'h08, SCR_HOURS = 5'h09, SCR_PASSES = 5'h0a, SCR_FAILS = 5'h0b,
    SCR_ALL_SEGMENTS = 5'h0c, SCR_REVIEW_MENU = 5'h0d, SCR_TEST_MENU = 5'h0e,
    SCR_ADJUST_MENU = 5'h0f, SCR_PROBE_CHECK = 5'h10, SCR_SIM_PROMPT = 5'h11,
    SCR_SIM = 5'h12, SCR_CAL_ZERO = 5'h13, SCR_CAL_SPAN = 5'h14
  } gtmc_screen_t;
  typedef struct packed {
    gtmc_state_t state;
    gtmc_hold_t hold;
    logic [3:0] sy1;
    logic [3:0] sy2;
    logic [3:0] sy3;
    logic [16:0] pre;
    logic ms;
    logic [19:0] tmr;
    logic [19:0] htmr;
    logic [3:0] item;
    logic [8:0] bcnt;
    logic blink;
    logic [1:0] sim;
    logic [15:0] base;
    logic [15:0] held;
    logic [15:0] npass;
    logic [15:0] nfail;
    logic fail;
    logic passmsg;
    logic [15:0] loop;
    gtmc_screen_t scr;
    logic flock;
    logic ftest;
    logic ffail;
    logic fzero;
    logic fspan;
    logic fup;
    logic fdown;
    logic fpass;
  } gtmc_regs_t;
endpackage

//--- gtmc_mode_ctrl.sv
/*
  Operating-mode controller of a loop-powered gas transmitter: power-up
  display sequence, start-up output lock, operator menu, output simulation,
  manual sensor self-test with staged output release, and indicator flags.
  Assumes the four magnetic keys arrive asynchronously, and that the sensing
  module interface delivers CONC, FULL_SCALE and TRACK_UA on SYS_CLK.
*/
// Summary of operation
// - Power-up shows twelve review_menu screens in order
// - Then show concentration, lock output at 4 mA
// - Oxygen module locks output at 17.4 mA instead
// - Delay expiry clears lock, output tracks gas
// - After sequence and delay, enter normal state
// - Four magnetic keys: mode, enter, up, down
// - Mode steps review, diagnostics, adjustment menus
// - Enter at review replays power-up review_menu
// - Simulation forces 4, 12 or 20 mA
// - Simulation failure choice drives about 3.6 mA
// - Diagnostics enter with generator shows probe prompt
// - Enter at prompt starts test, flag flashes
// - Mode at prompt leaves without testing
// - Test freezes output at its previous value
// - Pass when concentration 10% above start
// - On pass, test flag turns steady on
// - After pass, full output hold two minutes
// - Partial hold eight minutes, released above half range
// - Zero and span flags during adjustment steps
// - Up and down flags follow their keys
// - Fail flag lit on self-test failure
// - Lock flag during simulation or any hold
`include "gtmc_defines.svh"

module gtmc_mode_ctrl #(
  parameter int TICK_CYC = (`GTMC_TICK_NS + `GTMC_CLK_NS - 1) / `GTMC_CLK_NS,
  parameter int STARTUP_MS = `GTMC_STARTUP_MS,
  parameter int FULLHOLD_MS = `GTMC_FULLHOLD_MS,
  parameter int PARTHOLD_MS = `GTMC_PARTHOLD_MS,
  parameter int TESTWIN_MS = `GTMC_TESTWIN_MS
)(
  input wire logic SYS_CLK, // System clock
  input wire logic RST_N, // Asynchronous reset
  input wire logic MODE_KEY, // Mode step magnet
  input wire logic ENTER_KEY, // Enter magnet
  input wire logic UP_KEY, // Up magnet
  input wire logic DOWN_KEY, // Down magnet
  input wire logic MOD_OXYGEN, // Module measures oxygen
  input wire logic MOD_GENERATOR, // Module has gas generator
  input wire logic [15:0] CONC, // Measured concentration
  input wire logic [15:0] FULL_SCALE, // Module full-scale range
  input wire logic [15:0] TRACK_UA, // Loop current for CONC
  output gtmc_pkg::gtmc_screen_t SCREEN, // Display screen code
  output logic [15:0] LOOP_UA, // Loop current command
  output logic [15:0] PASS_COUNT, // Self-test passes
  output logic [15:0] FAIL_COUNT, // Self-test failures
  output logic FLAG_LOCK, // Output lock indicator
  output logic FLAG_TEST, // Self-test indicator
  output logic FLAG_FAIL, // Fail indicator
  output logic FLAG_ZERO, // Zero indicator
  output logic FLAG_SPAN, // Span indicator
  output logic FLAG_UP, // Up key indicator
  output logic FLAG_DOWN, // Down key indicator
  output logic FLAG_PASS // Pass message, flashing
);
  import gtmc_pkg::*;

  localparam int STEP_MS = `GTMC_STEP_MS;
  localparam int BLINK_MS = `GTMC_BLINK_MS;

  gtmc_regs_t r;
  gtmc_regs_t n;
  logic [3:0] key;
  logic [16:0] thr;
  logic [15:0] lock_ua;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic hit(input logic [3:0] k, input int i);
    return k[i];
  endfunction

  function automatic logic [15:0] sim_ua(input logic [1:0] sel);
    unique case (sel)
      2'h0: return `GTMC_LOCK_UA;
      2'h1: return `GTMC_MID_UA;
      2'h2: return `GTMC_FULL_UA;
      default: return `GTMC_TROUBLE_UA;
    endcase
  endfunction

  function automatic logic done(input logic ms, input logic [19:0] t, input int lim);
    return ms && (t == 20'(lim - 1));
  endfunction

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    n = r;
    // Keys only reach logic after two flops; third flop gives the edge
    n.sy1 = {DOWN_KEY, UP_KEY, ENTER_KEY, MODE_KEY};
    n.sy2 = r.sy1;
    n.sy3 = r.sy2;
    key = r.sy2 & ~r.sy3;
    thr = {1'b0, r.base} + {1'b0, r.base / `GTMC_PASS_DIV};
    lock_ua = MOD_OXYGEN ? `GTMC_O2_LOCK_UA : `GTMC_LOCK_UA;
    // Millisecond tick keeps the long timers narrow
    if (r.pre == 17'(TICK_CYC - 1))
    begin
      n.pre = '0;
      n.ms = 1'b1;
    end
    else
    begin
      n.pre = r.pre + 17'h00001;
      n.ms = 1'b0;
    end
    if (r.ms)
    begin
      n.tmr = r.tmr + 20'h00001;
      n.htmr = r.htmr + 20'h00001;
      n.bcnt = r.bcnt + 9'h001;
      if (r.bcnt == 9'(BLINK_MS - 1))
      begin
        n.bcnt = '0;
        n.blink = ~r.blink;
      end
    end
    unique case (r.state)
      ST_POWERUP, ST_REVIEW_MENU_SHOW:
      begin
        if (done(r.ms, r.tmr, STEP_MS))
        begin
          n.tmr = '0;
          n.item = r.item + 4'h1;
          if (r.item == `GTMC_ITEM_LAST)
          begin
            n.item = '0;
            n.state = (r.state == ST_POWERUP) ? ST_DELAY : ST_NORMAL;
          end
        end
      end
      ST_DELAY:
        if (done(r.ms, r.tmr, STARTUP_MS))
          n.state = ST_NORMAL;
      ST_NORMAL:
      begin
        if (hit(key, 0))
          n.state = ST_MENU_REVIEW_MENU;
        else if (hit(key, 1))
          n.fail = 1'b0;
      end
      ST_MENU_REVIEW_MENU:
      begin
        if (hit(key, 0))
          n.state = ST_MENU_TEST;
        else if (hit(key, 1))
        begin
          n.state = ST_REVIEW_MENU_SHOW;
          n.item = '0;
          n.tmr = '0;
        end
      end
      ST_MENU_TEST:
      begin
        if (hit(key, 0))
          n.state = ST_MENU_CAL;
        else if (hit(key, 1))
          n.state = MOD_GENERATOR ? ST_PROBE : ST_SIM_PROMPT;
      end
      ST_MENU_CAL:
      begin
        if (hit(key, 0))
          n.state = ST_NORMAL;
        else if (hit(key, 1))
          n.state = ST_CAL_ZERO;
      end
      ST_PROBE:
      begin
        if (hit(key, 1))
        begin
          n.state = ST_SELFTEST;
          n.tmr = '0;
          n.base = CONC;
          n.held = r.loop;
          n.hold = HOLD_NONE;
          n.passmsg = 1'b0;
        end
        else if (hit(key, 0))
          n.state = ST_SIM_PROMPT;
      end
      ST_SIM_PROMPT:
      begin
        if (hit(key, 1))
        begin
          n.state = ST_SIM;
          n.sim = 2'h0;
        end
        else if (hit(key, 0))
          n.state = ST_NORMAL;
      end
      ST_SIM:
      begin
        if (hit(key, 1))
          n.state = ST_NORMAL;
        else if (hit(key, 2))
          n.sim = r.sim + 2'h1;
        else if (hit(key, 3))
          n.sim = r.sim - 2'h1;
      end
      ST_SELFTEST:
      begin
        if ({1'b0, CONC} > {1'b0, r.base} && {1'b0, CONC} >= thr)
        begin
          n.state = ST_NORMAL;
          n.passmsg = 1'b1;
          n.npass = r.npass + 16'h0001;
          n.hold = HOLD_FULL;
          n.htmr = '0;
        end
        else if (done(r.ms, r.tmr, TESTWIN_MS))
        begin
          n.state = ST_NORMAL;
          n.fail = 1'b1;
          n.nfail = r.nfail + 16'h0001;
        end
      end
      ST_CAL_ZERO:
      begin
        if (hit(key, 1))
          n.state = ST_CAL_SPAN;
        else if (hit(key, 0))
          n.state = ST_NORMAL;
      end
      ST_CAL_SPAN:
        if (hit(key, 1) || hit(key, 0))
          n.state = ST_NORMAL;
    endcase
    // Hold stages run alongside the menus so the operator may keep browsing
    unique case (r.hold)
      HOLD_FULL:
        if (done(r.ms, r.htmr, FULLHOLD_MS))
        begin
          n.hold = HOLD_PART;
          n.htmr = '0;
          n.passmsg = 1'b0;
        end
      HOLD_PART:
        if (CONC > (FULL_SCALE >> 1) || done(r.ms, r.htmr, PARTHOLD_MS))
          n.hold = HOLD_NONE;
      HOLD_NONE:
      begin
        // Leave n.hold alone: a pass in this cycle starts the full hold
      end
      default:
        n.hold = HOLD_NONE;
    endcase
    // ************************************************************
    // Outputs, registered from the next state
    // ************************************************************
    n.loop = TRACK_UA;
    n.scr = SCR_CONC;
    if (n.state == ST_POWERUP || n.state == ST_DELAY || n.state == ST_CAL_ZERO || n.state == ST_CAL_SPAN)
      n.loop = lock_ua;
    else if (n.state == ST_SIM)
      n.loop = sim_ua(n.sim);
    else if (n.state == ST_SELFTEST || n.hold != HOLD_NONE)
      n.loop = n.held;
    unique case (n.state)
      ST_POWERUP, ST_REVIEW_MENU_SHOW: n.scr = gtmc_screen_t'(5'(n.item) + 5'h01);
      ST_MENU_REVIEW_MENU: n.scr = SCR_REVIEW_MENU;
      ST_MENU_TEST: n.scr = SCR_TEST_MENU;
      ST_MENU_CAL: n.scr = SCR_ADJUST_MENU;
      ST_PROBE: n.scr = SCR_PROBE_CHECK;
      ST_SIM_PROMPT: n.scr = SCR_SIM_PROMPT;
      ST_SIM: n.scr = SCR_SIM;
      ST_CAL_ZERO: n.scr = SCR_CAL_ZERO;
      ST_CAL_SPAN: n.scr = SCR_CAL_SPAN;
      default: n.scr = SCR_CONC;
    endcase
    n.flock = (n.state == ST_POWERUP) || (n.state == ST_DELAY) || (n.state == ST_SIM) ||
              (n.state == ST_SELFTEST) || (n.state == ST_CAL_ZERO) || (n.state == ST_CAL_SPAN) ||
              (n.hold != HOLD_NONE);
    n.ftest = (n.state == ST_PROBE) || (n.hold != HOLD_NONE) ||
              (n.state == ST_SELFTEST && n.blink);
    n.fpass = n.passmsg && n.blink;
    n.ffail = n.fail;
    n.fzero = (n.state == ST_CAL_ZERO);
    n.fspan = (n.state == ST_CAL_SPAN);
    n.fup = r.sy2[2];
    n.fdown = r.sy2[3];
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      r <= '0;
      r.state <= ST_POWERUP;
      r.hold <= HOLD_NONE;
      r.loop <= `GTMC_LOCK_UA;
      r.scr <= SCR_LOAD;
      r.flock <= 1'b1;
    end
    else
      r <= n;
  end

  assign SCREEN = r.scr;
  assign LOOP_UA = r.loop;
  assign PASS_COUNT = r.npass;
  assign FAIL_COUNT = r.nfail;
  assign FLAG_LOCK = r.flock;
  assign FLAG_TEST = r.ftest;
  assign FLAG_FAIL = r.ffail;
  assign FLAG_ZERO = r.fzero;
  assign FLAG_SPAN = r.fspan;
  assign FLAG_UP = r.fup;
  assign FLAG_DOWN = r.fdown;
  assign FLAG_PASS = r.fpass;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  powerup_order_a: assert property (
    (r.state == ST_POWERUP && $past(r.state) == ST_POWERUP && r.item != $past(r.item))
    |-> r.item == $past(r.item) + 4'h1)
    else $error("Power-up screens out of order");
  startup_lock_a: assert property (
    (r.state == ST_DELAY && $past(r.state) == ST_DELAY)
    |-> r.flock && r.loop == ($past(MOD_OXYGEN) ? `GTMC_O2_LOCK_UA : `GTMC_LOCK_UA))
    else $error("Start-up lock value wrong");
  delay_release_a: assert property (
    $fell(r.state == ST_DELAY) |-> r.state == ST_NORMAL && !r.flock && r.loop == $past(TRACK_UA))
    else $error("Output not released after delay");
  menu_step_a: assert property (
    (r.state == ST_NORMAL && r.sy2[0] && !r.sy3[0]) |=> r.state == ST_MENU_REVIEW_MENU ##0 r.scr == SCR_REVIEW_MENU)
    else $error("Mode key did not open review menu");
  sim_value_a: assert property (
    r.state == ST_SIM |-> r.flock && r.loop == sim_ua(r.sim))
    else $error("Simulated current wrong");
  test_freeze_a: assert property (
    r.state == ST_SELFTEST |-> r.flock && r.loop == r.held ##1 (r.state != ST_SELFTEST || r.loop == $past(r.loop)))
    else $error("Output moved during self-test");
  pass_hold_a: assert property (
    $rose(r.hold == HOLD_FULL) |-> r.npass == $past(r.npass) + 16'h0001 && r.ftest && r.loop == $past(r.loop))
    else $error("Pass did not count or hold");
  part_release_a: assert property (
    (r.hold == HOLD_PART && CONC > (FULL_SCALE >> 1)) |=> r.hold == HOLD_NONE ##1 r.loop == $past(TRACK_UA))
    else $error("Partial hold not released");
  fail_latch_a: assert property (
    $rose(r.fail) |-> r.nfail == $past(r.nfail) + 16'h0001 && r.ffail)
    else $error("Failure not counted or flagged");
endmodule

//--- gtmc_sensor_model.sv
/*
  Sensing module model: turns the gas level at the sensor into
  concentration and the loop current that tracks it, beside a fixed full scale.
  Assumes the controller's SYS_CLK and a full scale of FS units.
*/
module gtmc_sensor_model #(
  parameter int FS = 1000
)(
  input wire logic SYS_CLK, // System clock
  input wire logic [15:0] GAS_LEVEL, // Gas at the sensor
  output logic [15:0] CONC, // Measured concentration
  output logic [15:0] FULL_SCALE, // Full-scale range
  output logic [15:0] TRACK_UA // Loop current for CONC
);
  timeunit 1ns;
  timeprecision 1ps;
  assign FULL_SCALE = 16'(FS);
  // Registered, so a reading moves on clock edges like a real converter
  always_ff @(posedge SYS_CLK)
  begin
    CONC <= GAS_LEVEL;
    TRACK_UA <= 16'(32'h0fa0 + (32'(GAS_LEVEL) * 32'h3e80) / FS);
  end
endmodule

//--- gtmc_mode_ctrl_tb.sv
/*
  Self-checking bench of the mode controller with a sensing module model.
  Assumes short timer parameters: one ms tick is two clock cycles.
*/
`include "gtmc_defines.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
`define WAIT(c, n) begin int w; w = 0; while (!(c) && w < (n)) begin tick(1); w++; end \
  checked++; if (!(c)) begin bad_count++; $display("Error wait expected 1 seen 0"); report_and_stop(); end end

module gtmc_mode_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import gtmc_pkg::*;
  localparam int FS = 1000;
  logic sys_clk, rst_n, ox, gen;
  logic [3:0] keys;
  logic [15:0] gas, conc, fs, track, loop_ua, npass, nfail, held;
  gtmc_screen_t screen;
  logic f_lock, f_test, f_fail, f_zero, f_span, f_up, f_down, f_pass;
  int bad_count, checked, base;
  logic [15:0] seq [5] = '{`GTMC_LOCK_UA, `GTMC_MID_UA, `GTMC_FULL_UA, `GTMC_TROUBLE_UA, `GTMC_LOCK_UA};

  gtmc_sensor_model #(.FS(FS)) i_sensor (.SYS_CLK(sys_clk), .GAS_LEVEL(gas), .CONC(conc),
    .FULL_SCALE(fs), .TRACK_UA(track));
  // Full hold and test window outlast one blink period, so both flashing flags show
  gtmc_mode_ctrl #(.TICK_CYC(2), .STARTUP_MS(20), .FULLHOLD_MS(1200), .PARTHOLD_MS(10),
    .TESTWIN_MS(1500)) i_dut (.SYS_CLK(sys_clk), .RST_N(rst_n), .MODE_KEY(keys[0]),
    .ENTER_KEY(keys[1]), .UP_KEY(keys[2]), .DOWN_KEY(keys[3]), .MOD_OXYGEN(ox),
    .MOD_GENERATOR(gen), .CONC(conc), .FULL_SCALE(fs), .TRACK_UA(track), .SCREEN(screen),
    .LOOP_UA(loop_ua), .PASS_COUNT(npass), .FAIL_COUNT(nfail), .FLAG_LOCK(f_lock),
    .FLAG_TEST(f_test), .FLAG_FAIL(f_fail), .FLAG_ZERO(f_zero), .FLAG_SPAN(f_span),
    .FLAG_UP(f_up), .FLAG_DOWN(f_down), .FLAG_PASS(f_pass));

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ****************
  // Helpers
  // ****************
  function automatic logic [15:0] exp_track(int c);
    return 16'(32'h0fa0 + (c * 32'h3e80) / FS);
  endfunction

  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Key held long enough for the synchroniser, then released for a clean edge
  task automatic press(int k);
    keys[k] = 1'b1;
    tick(6);
    if (k == 2) `CHK("up flag", 1'b1, f_up)
    if (k == 3) `CHK("down flag", 1'b1, f_down)
    keys[k] = 1'b0;
    tick(6);
  endtask

  task automatic end_test(string nm);
    $display("test %s done, mismatches so far %0d", nm, bad_count);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic power_up(logic o, bit full);
    rst_n = 1'b0;
    ox = o;
    tick(16);
    `CHK("reset screen", SCR_LOAD, screen)
    `CHK("reset lock", 1'b1, f_lock)
    rst_n = 1'b1;
    if (full)
      for (int i = 1; i <= 12; i++) `WAIT(screen === gtmc_screen_t'(i), 2200)
    `WAIT(screen === SCR_CONC, 30000)
    `CHK("delay loop", o ? `GTMC_O2_LOCK_UA : `GTMC_LOCK_UA, loop_ua)
    `CHK("delay lock", 1'b1, f_lock)
    `WAIT(f_lock === 1'b0, 100)
    tick(2);
    `CHK("released loop", exp_track(gas), loop_ua)
  endtask

  // ****************
  // Main sequence
  // ****************
  initial
  begin
    rst_n = 1'b0;
    keys = 4'h0;
    ox = 1'b0;
    gen = 1'b0;
    gas = 16'h00c8;
    bad_count = 0;
    checked = 0;
    void'($urandom(96));
    power_up(1'b1, 1'b1);
    end_test("oxygen power-up");
    power_up(1'b0, 1'b0);
    end_test("start-up lock");
    for (int i = 0; i < 4; i++)
    begin
      press(0);
      `CHK("menu", i == 3 ? SCR_CONC : gtmc_screen_t'(5'h0d + i), screen)
    end
    press(0);
    press(1);
    for (int i = 1; i <= 12; i++) `WAIT(screen === gtmc_screen_t'(i), 2200)
    `WAIT(screen === SCR_CONC, 2200)
    end_test("menus and review");
    press(0);
    press(0);
    press(1);
    `CHK("sim prompt", SCR_SIM_PROMPT, screen)
    press(1);
    `CHK("sim loop", seq[0], loop_ua)
    `CHK("sim lock", 1'b1, f_lock)
    for (int i = 1; i < 5; i++)
    begin
      press(2);
      `CHK("sim up", seq[i], loop_ua)
    end
    for (int i = 3; i >= 0; i--)
    begin
      press(3);
      `CHK("sim down", seq[i], loop_ua)
    end
    press(1);
    `CHK("sim exit", SCR_CONC, screen)
    end_test("simulation");
    for (int i = 0; i < 3; i++) press(0);
    press(1);
    `CHK("zero flag", 1'b1, f_zero)
    press(1);
    `CHK("span flag", 1'b1, f_span)
    press(1);
    `CHK("cal exit", SCR_CONC, screen)
    gen = 1'b1;
    press(0);
    press(0);
    press(1);
    `CHK("probe screen", SCR_PROBE_CHECK, screen)
    `CHK("probe flag", 1'b1, f_test)
    press(0);
    `CHK("probe escape", SCR_SIM_PROMPT, screen)
    `CHK("no test run", 16'h0000, npass)
    press(0);
    end_test("adjust and probe");
    base = 100 + $urandom_range(399);
    gas = 16'(base);
    held = exp_track(base);
    tick(4);
    press(0);
    press(0);
    press(1);
    press(1);
    `WAIT(f_test === 1'b1, 1100)
    `WAIT(f_test === 1'b0, 1100)
    gas = 16'(base + base / 10 - 1);
    tick(10);
    `CHK("below threshold", 16'h0000, npass)
    `CHK("frozen loop", held, loop_ua)
    gas = 16'(base + base / 10);
    `WAIT(npass === 16'h0001, 20)
    gas = 16'h0258;
    tick(10);
    `CHK("full hold loop", held, loop_ua)
    `CHK("steady flag", 1'b1, f_test)
    `CHK("hold lock", 1'b1, f_lock)
    `WAIT(f_pass === 1'b1, 1100)
    `CHK("pass hold loop", held, loop_ua)
    `WAIT(loop_ua === exp_track(600), 2500)
    tick(2);
    `CHK("lock off", 1'b0, f_lock)
    end_test("self-test pass");
    gas = 16'(base);
    tick(4);
    press(0);
    press(0);
    press(1);
    press(1);
    `WAIT(nfail === 16'h0001, 3100)
    `CHK("fail flag", 1'b1, f_fail)
    `CHK("fail screen", SCR_CONC, screen)
    press(1);
    `CHK("fail cleared", 1'b0, f_fail)
    end_test("self-test fail");
    report_and_stop();
  end
endmodule
